// [rtl/cmr_map.svh]
// register offsets, field positions, reset values and decode figures of the charger bank
`ifndef CMR_MAP_SVH
`define CMR_MAP_SVH

// register pointer values on the serial bus
`define CMR_OFS_IRQ_MASK   8'h07
`define CMR_OFS_THERM_THR  8'h20
`define CMR_OFS_INPUT_CFG  8'h21
`define CMR_RD_UNMAPPED    8'h00

// reset values; bit 0 of the input config is replaced by the factory bit
`define CMR_RST_IRQ_MASK   8'hff
`define CMR_RST_THERM_THR  8'h0f
`define CMR_RST_INPUT_CFG  8'h10

// field positions
`define CMR_NUM_EVT        7
`define CMR_F_EVT_MASK     6:0
`define CMR_F_HOT          7:6
`define CMR_F_WARM         5:4
`define CMR_F_COOL         3:2
`define CMR_F_COLD         1:0
`define CMR_F_VMIN         7:5
`define CMR_F_ILIM         4:2
`define CMR_B_PQ           1
`define CMR_B_EN           0

// threshold tables in millivolts, code 3 in the top slice, 11 bits a slot
`define CMR_THR_W          11
`define CMR_HOT_MV_TBL     {11'd291, 11'd327, 11'd367, 11'd411}
`define CMR_WARM_MV_TBL    {11'd367, 11'd411, 11'd459, 11'd511}
`define CMR_COOL_MV_TBL    {11'd747, 11'd807, 11'd867, 11'd923}
`define CMR_COLD_MV_TBL    {11'd867, 11'd923, 11'd976, 11'd1024}

// linear settings
`define CMR_VMIN_BASE_MV   13'd4000
`define CMR_VMIN_STEP_MV   13'd100
`define CMR_ILIM_STEP_MA   9'd95
`define CMR_ILIM_MAX_CODE  3'h4
`define CMR_PQ_LO_PCT      5'd10
`define CMR_PQ_HI_PCT      5'd20

// serial bus byte length in bits
`define CMR_BYTE_BITS      4'h8

`endif

// [rtl/cmr_pkg.sv]
// types shared by the charger mask and config register bank
package cmr_pkg;

    // serial slave sequencer, one-hot
    typedef enum logic [7:0] {
        CMR_IDLE  = 8'h01,
        CMR_ADDR  = 8'h02,
        CMR_AACK  = 8'h04,
        CMR_PTR   = 8'h08,
        CMR_WDATA = 8'h10,
        CMR_WACK  = 8'h20,
        CMR_RDATA = 8'h40,
        CMR_RACK  = 8'h80
    } cmr_st_t;

    typedef struct packed {
        cmr_st_t    st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic       rw;
        logic       nack;
        logic       oe;
        logic       scl_p;
        logic       sda_p;
        logic [7:0] mask;
        logic [7:0] thr;
        logic [7:0] incfg;
        logic       irq;
    } cmr_regs_t;

    typedef struct packed {
        logic [10:0] hot_mv;
        logic [10:0] warm_mv;
        logic [10:0] cool_mv;
        logic [10:0] cold_mv;
        logic [12:0] vmin_mv;
        logic [8:0]  ilim_ma;
        logic        ilim_rsvd;
        logic [4:0]  pq_pct;
    } cmr_dec_t;

endpackage : cmr_pkg

// [rtl/cmr_sync.sv]
// three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
`default_nettype none

module cmr_sync #(
    parameter int         W   = 2,
    parameter logic [1:0] RST = 2'h3
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    // pins and filtered levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] lvl_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } cmr_sync_t;

    cmr_sync_t q;
    cmr_sync_t d;

    // stage one feeds only stage two; the level moves once two and three agree
    always_comb begin
        d    = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
        if (srst_i) begin
            d = '{s1: RST[W-1:0], s2: RST[W-1:0], s3: RST[W-1:0], lvl: RST[W-1:0]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        q <= d;
    end

    assign lvl_o = q.lvl;

endmodule : cmr_sync
`default_nettype wire

// [rtl/cmr_decode.sv]
// turns threshold, input-voltage, current-limit and precharge codes into settings
`timescale 1ns/1ps
`default_nettype none
`include "cmr_map.svh"

module cmr_decode
    import cmr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // register contents and the order select strap
    input  wire logic [7:0]  thr_i,
    input  wire logic [7:0]  incfg_i,
    input  wire logic        current_limit_order_select_i,
    // decoded settings, registered
    output logic      [10:0] hot_mv_o,
    output logic      [10:0] warm_mv_o,
    output logic      [10:0] cool_mv_o,
    output logic      [10:0] cold_mv_o,
    output logic      [12:0] vmin_mv_o,
    output logic      [8:0]  ilim_ma_o,
    output logic             ilim_rsvd_o,
    output logic      [4:0]  pq_pct_o
);
    cmr_dec_t q;
    cmr_dec_t d;
    logic [2:0] ilim_code;
    logic [2:0] ilim_eff;

    // one slot of a four-entry threshold table
    function automatic logic [10:0] pick(input logic [43:0] tbl, input logic [1:0] code);
        pick = tbl[code*`CMR_THR_W +: `CMR_THR_W];
    endfunction : pick

    always_comb begin
        d           = q;
        ilim_code   = incfg_i[`CMR_F_ILIM];
        ilim_eff    = ilim_code;
        d.hot_mv    = pick(`CMR_HOT_MV_TBL, thr_i[`CMR_F_HOT]);
        d.warm_mv   = pick(`CMR_WARM_MV_TBL, thr_i[`CMR_F_WARM]);
        d.cool_mv   = pick(`CMR_COOL_MV_TBL, thr_i[`CMR_F_COOL]);
        d.cold_mv   = pick(`CMR_COLD_MV_TBL, thr_i[`CMR_F_COLD]);
        d.vmin_mv   = `CMR_VMIN_BASE_MV
                    + 13'(incfg_i[`CMR_F_VMIN]) * `CMR_VMIN_STEP_MV;
        // reversed order counts down from the top code
        if (current_limit_order_select_i) begin
            ilim_eff = `CMR_ILIM_MAX_CODE - ilim_code;
        end
        // reserved codes give no limit value rather than a guessed one
        d.ilim_rsvd = (ilim_code > `CMR_ILIM_MAX_CODE);
        d.ilim_ma   = d.ilim_rsvd ? 9'h000
                    : (9'(ilim_eff) + 9'h001) * `CMR_ILIM_STEP_MA;
        d.pq_pct    = incfg_i[`CMR_B_PQ] ? `CMR_PQ_HI_PCT : `CMR_PQ_LO_PCT;
        if (srst_i) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        q <= d;
    end

    assign hot_mv_o    = q.hot_mv;
    assign warm_mv_o   = q.warm_mv;
    assign cool_mv_o   = q.cool_mv;
    assign cold_mv_o   = q.cold_mv;
    assign vmin_mv_o   = q.vmin_mv;
    assign ilim_ma_o   = q.ilim_ma;
    assign ilim_rsvd_o = q.ilim_rsvd;
    assign pq_pct_o    = q.pq_pct;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_hot_code3;
        thr_i[7:6] == 2'h3;
    endsequence
    property p_hot;
        s_hot_code3 |=> hot_mv_o == 11'd291;
    endproperty
    a_hot: assert property (p_hot) else $error("hot threshold wrong");
    property p_warm;
        thr_i[5:4] == 2'h0 |=> warm_mv_o == 11'd511;
    endproperty
    a_warm: assert property (p_warm) else $error("warm threshold wrong");
    property p_cool;
        thr_i[3:2] == 2'h2 |=> cool_mv_o == 11'd807;
    endproperty
    a_cool: assert property (p_cool) else $error("cool threshold wrong");
    property p_cold;
        thr_i[1:0] == 2'h1 |=> cold_mv_o == 11'd976;
    endproperty
    a_cold: assert property (p_cold) else $error("cold threshold wrong");
    property p_vmin;
        incfg_i[7:5] == 3'h7 |=> vmin_mv_o == 13'd4700;
    endproperty
    a_vmin: assert property (p_vmin) else $error("min input voltage wrong");
    property p_ilim;
        incfg_i[4:2] == 3'h1 && !current_limit_order_select_i |=> ilim_ma_o == 9'd190;
    endproperty
    a_ilim: assert property (p_ilim) else $error("current limit wrong");
    property p_ilim_rev;
        incfg_i[4:2] == 3'h0 && current_limit_order_select_i |=> ilim_ma_o == 9'd475;
    endproperty
    a_ilim_rev: assert property (p_ilim_rev) else $error("reversed limit wrong");
    property p_pq;
        incfg_i[1] ##1 incfg_i[1] |=> pq_pct_o == 5'd20 && $past(pq_pct_o) == 5'd20;
    endproperty
    a_pq: assert property (p_pq) else $error("precharge ratio wrong");

endmodule : cmr_decode
`default_nettype wire

// [rtl/cmr_regs.sv]
// charger interrupt mask and config register bank behind a serial slave port
// Functional notes
// - a set mask bit stops its event flag reaching the interrupt; clear passes it
// - hot field bits 7:6 picks 0.411, 0.367, 0.327 or 0.291 volts
// - warm field bits 5:4 picks 0.511, 0.459, 0.411 or 0.367 volts
// - cool field bits 3:2 picks 0.923, 0.867, 0.807 or 0.747 volts
// - cold field bits 1:0 picks 1.024, 0.976, 0.923 or 0.867 volts
// - input minimum voltage bits 7:5: 4.0 volts plus 0.1 volts per step
// - input current limit bits 4:2: 95 mA steps up to 475; above four reserved
// - order select high reverses the current limit code to value mapping
// - bit 1 sets precharge current at ten or twenty percent of fast charge
// - bit 0 enables the charger; its reset value comes from factory memory
`timescale 1ns/1ps
`default_nettype none
`include "cmr_map.svh"

module cmr_regs
    import cmr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary bus address
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // serial control bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // event flags and strap inputs
    input  wire logic [6:0]  evt_flags_i,
    input  wire logic        otp_charger_en_i,
    input  wire logic        current_limit_order_select_i,
    // interrupt and charger controls
    output logic             irq_o,
    output logic             charger_enable_bit_o,
    output logic      [10:0] hot_mv_o,
    output logic      [10:0] warm_mv_o,
    output logic      [10:0] cool_mv_o,
    output logic      [10:0] cold_mv_o,
    output logic      [12:0] vmin_mv_o,
    output logic      [8:0]  ilim_ma_o,
    output logic             ilim_rsvd_o,
    output logic      [4:0]  pq_pct_o
);
    cmr_regs_t  q;
    cmr_regs_t  d;
    logic       scl;
    logic       sda;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] rd_byte;
    logic [7:0] sh_next;

    // readback of the bank; unmapped pointers read as zero
    function automatic logic [7:0] rd_fn(input cmr_regs_t r);
        case (r.ptr)
            `CMR_OFS_IRQ_MASK:  rd_fn = r.mask;
            `CMR_OFS_THERM_THR: rd_fn = r.thr;
            `CMR_OFS_INPUT_CFG: rd_fn = r.incfg;
            default:            rd_fn = `CMR_RD_UNMAPPED;
        endcase
    endfunction : rd_fn

    // pins cross in through four flops, three stages and the filtered level, before any edge is looked at
    cmr_sync #(
        .W   (2),
        .RST (2'h3)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .pin_i     ({scl_i, sda_i}),
        .lvl_o     ({scl, sda})
    );

    // bus conditions from the filtered levels
    assign rise  = scl & ~q.scl_p;
    assign fall  = ~scl & q.scl_p;
    assign start = scl & q.scl_p & q.sda_p & ~sda;
    assign stop  = scl & q.scl_p & ~q.sda_p & sda;

    // slave sequencer, register bank and interrupt combine
    always_comb begin
        d       = q;
        rd_byte = rd_fn(q);
        sh_next = {q.sh[6:0], 1'b0};
        d.scl_p = scl;
        d.sda_p = sda;
        // unmasked flags only; bit 7 of the mask gates nothing
        d.irq   = |(evt_flags_i & ~q.mask[`CMR_F_EVT_MASK]);
        if (start) begin
            // a repeated start lands here as well and keeps the pointer
            d.st  = CMR_ADDR;
            d.cnt = 4'h0;
            d.oe  = 1'b0;
        end else if (stop) begin
            d.st = CMR_IDLE;
            d.oe = 1'b0;
        end else if (rise) begin
            case (q.st)
                CMR_ADDR, CMR_PTR, CMR_WDATA: begin
                    d.sh  = {q.sh[6:0], sda};
                    d.cnt = q.cnt + 4'h1;
                end
                CMR_RDATA: begin
                    d.cnt = q.cnt + 4'h1;
                end
                CMR_RACK: begin
                    d.nack = sda;
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            case (q.st)
                CMR_ADDR: begin
                    if (q.cnt == `CMR_BYTE_BITS) begin
                        if (q.sh[7:1] == DEV_ADDR) begin
                            d.rw = q.sh[0];
                            d.oe = 1'b1;
                            d.st = CMR_AACK;
                        end else begin
                            d.st = CMR_IDLE;
                        end
                    end
                end
                CMR_AACK: begin
                    d.cnt = 4'h0;
                    if (q.rw) begin
                        d.sh = rd_byte;
                        d.oe = ~rd_byte[7];
                        d.st = CMR_RDATA;
                    end else begin
                        d.oe = 1'b0;
                        d.st = CMR_PTR;
                    end
                end
                CMR_PTR: begin
                    if (q.cnt == `CMR_BYTE_BITS) begin
                        d.ptr = q.sh;
                        d.oe  = 1'b1;
                        d.st  = CMR_WACK;
                    end
                end
                CMR_WDATA: begin
                    if (q.cnt == `CMR_BYTE_BITS) begin
                        // bit 7 of the mask is stored as written
                        case (q.ptr)
                            `CMR_OFS_IRQ_MASK:  d.mask  = q.sh;
                            `CMR_OFS_THERM_THR: d.thr   = q.sh;
                            `CMR_OFS_INPUT_CFG: d.incfg = q.sh;
                            default: begin
                            end
                        endcase
                        d.ptr = q.ptr + 8'h01;
                        d.oe  = 1'b1;
                        d.st  = CMR_WACK;
                    end
                end
                CMR_WACK: begin
                    d.oe  = 1'b0;
                    d.cnt = 4'h0;
                    d.st  = CMR_WDATA;
                end
                CMR_RDATA: begin
                    if (q.cnt == `CMR_BYTE_BITS) begin
                        d.oe  = 1'b0;
                        d.ptr = q.ptr + 8'h01;
                        d.st  = CMR_RACK;
                    end else begin
                        d.sh = sh_next;
                        d.oe = ~sh_next[7];
                    end
                end
                CMR_RACK: begin
                    // a nack ends the read; the master then sends stop
                    if (!q.nack) begin
                        d.sh  = rd_byte;
                        d.oe  = ~rd_byte[7];
                        d.cnt = 4'h0;
                        d.st  = CMR_RDATA;
                    end else begin
                        d.st = CMR_IDLE;
                    end
                end
                default: begin
                    d.st = CMR_IDLE;
                end
            endcase
        end
        if (srst_i) begin
            d       = '0;
            d.st    = CMR_IDLE;
            d.scl_p = 1'b1;
            d.sda_p = 1'b1;
            d.mask  = `CMR_RST_IRQ_MASK;
            d.thr   = `CMR_RST_THERM_THR;
            d.incfg = `CMR_RST_INPUT_CFG;
            // enable comes up as the factory bit, loaded while reset is held
            d.incfg[`CMR_B_EN] = otp_charger_en_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        q <= d;
    end

    // decoded settings are registered inside the decoder
    cmr_decode u_decode (
        .clk_sys_i                    (clk_sys_i),
        .srst_i                       (srst_i),
        .thr_i                        (q.thr),
        .incfg_i                      (q.incfg),
        .current_limit_order_select_i (current_limit_order_select_i),
        .hot_mv_o                     (hot_mv_o),
        .warm_mv_o                    (warm_mv_o),
        .cool_mv_o                    (cool_mv_o),
        .cold_mv_o                    (cold_mv_o),
        .vmin_mv_o                    (vmin_mv_o),
        .ilim_ma_o                    (ilim_ma_o),
        .ilim_rsvd_o                  (ilim_rsvd_o),
        .pq_pct_o                     (pq_pct_o)
    );

    // open-drain data: only the enable moves, the driven level is always low
    assign sda_o                = 1'b0;
    assign sda_oe_o             = q.oe;
    assign irq_o                = q.irq;
    assign charger_enable_bit_o = q.incfg[`CMR_B_EN];

    property p_irq_set;
        @(posedge clk_sys_i) disable iff (srst_i)
        |(evt_flags_i & ~q.mask[6:0]) |=> irq_o;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("unmasked flag lost");

    property p_irq_masked;
        @(posedge clk_sys_i) disable iff (srst_i)
        (evt_flags_i & ~q.mask[6:0]) == 7'h00 |=> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked flag raised irq");

    property p_otp_en;
        @(posedge clk_sys_i) disable iff (srst_i)
        $fell(srst_i) |-> charger_enable_bit_o == $past(otp_charger_en_i);
    endproperty
    a_otp_en: assert property (p_otp_en) else $error("enable not from factory bit");

endmodule : cmr_regs
`default_nettype wire

// [tb/cmr_host_model.sv]
// serial bus host model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
`default_nettype none

module cmr_host_model (
    // clock
    input  wire logic clk_sys_i,
    // bus wires, data line level comes back resolved with its pull-up
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // quarter bit in system clocks; keeps scl high and low well above six clocks
    localparam int QTR = 5;

    // idle bus: clock parked high, data released to the pull-up
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // every change lands on a falling system edge, clear of the sampling edge
    task automatic qwait(input int n);
        repeat (n * QTR) @(negedge clk_sys_i);
    endtask : qwait

    // start or repeated start; leaves scl low
    task automatic start();
        sda_low_o = 1'b0;
        qwait(1);
        scl_o = 1'b1;
        qwait(2);
        sda_low_o = 1'b1;
        qwait(2);
        scl_o = 1'b0;
        qwait(1);
    endtask : start

    task automatic stop();
        sda_low_o = 1'b1;
        qwait(1);
        scl_o = 1'b1;
        qwait(2);
        sda_low_o = 1'b0;
        qwait(2);
    endtask : stop

    // data changes only while scl is low, a quarter after the fall
    task automatic tx_bit(input logic b);
        sda_low_o = ~b;
        qwait(1);
        scl_o = 1'b1;
        qwait(2);
        scl_o = 1'b0;
        qwait(1);
    endtask : tx_bit

    task automatic rx_bit(output logic b);
        sda_low_o = 1'b0;
        qwait(1);
        scl_o = 1'b1;
        qwait(1);
        b = sda_i;
        qwait(1);
        scl_o = 1'b0;
        qwait(1);
    endtask : rx_bit

    task automatic tx_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) tx_bit(d[i]);
        rx_bit(b);
        ack = (b === 1'b0);
    endtask : tx_byte

    // last byte of a read is answered with a nack
    task automatic rx_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) rx_bit(d[i]);
        tx_bit(last);
    endtask : rx_byte

    // write one or two bytes from the pointer on; ok is high when all were acked
    task automatic write_regs(input logic [6:0] a, input logic [7:0] p,
                              input logic [15:0] d, input int n, output logic ok);
        logic k;
        start();
        tx_byte({a, 1'b0}, ok);
        if (ok) begin
            tx_byte(p, k);
            ok &= k;
            for (int j = 0; j < n; j++) begin
                tx_byte(d[8*j+:8], k);
                ok &= k;
            end
        end
        stop();
    endtask : write_regs

    // set the pointer, then read one or two bytes after a repeated start
    task automatic read_regs(input logic [6:0] a, input logic [7:0] p, input int n,
                             output logic [15:0] d, output logic ok);
        logic k;
        d = 16'h0000;
        start();
        tx_byte({a, 1'b0}, ok);
        tx_byte(p, k);
        ok &= k;
        start();
        tx_byte({a, 1'b1}, k);
        ok &= k;
        for (int j = 0; j < n; j++) rx_byte(j == n - 1, d[8*j+:8]);
        stop();
    endtask : read_regs
endmodule : cmr_host_model

`default_nettype wire

// [tb/cmr_regs_bench.sv]
// self-checking bench for the charger mask and config register bank
`timescale 1ns/1ps
`default_nettype none
`include "cmr_map.svh"

module cmr_regs_bench;
    localparam logic [6:0] DEV = 7'h2a;

    logic        clk_sys_i, srst_i, scl, sda_low, sda_w, sda_o, sda_oe_o;
    logic [6:0]  evt;
    logic        otp, order, irq_o, en_o, rsvd_o;
    logic [10:0] hot_o, warm_o, cool_o, cold_o;
    logic [12:0] vmin_o;
    logic [8:0]  ilim_o;
    logic [4:0]  pq_o;
    logic [31:0] seed = 32'hbec6b7ff;
    int          n_errors = 0;
    int          compares = 0;

    // open-drain wire: low when either side pulls, else the pull-up wins
    assign sda_w = ~(sda_low | (sda_oe_o & ~sda_o));

    cmr_regs #(.DEV_ADDR(DEV)) dut_u (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .evt_flags_i(evt), .otp_charger_en_i(otp),
        .current_limit_order_select_i(order), .irq_o(irq_o), .charger_enable_bit_o(en_o),
        .hot_mv_o(hot_o), .warm_mv_o(warm_o), .cool_mv_o(cool_o), .cold_mv_o(cold_o),
        .vmin_mv_o(vmin_o), .ilim_ma_o(ilim_o), .ilim_rsvd_o(rsvd_o), .pq_pct_o(pq_o));

    cmr_host_model host_u (
        .clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

    // 200 mhz system clock
    initial clk_sys_i = 1'b0;
    always #2.5 clk_sys_i = ~clk_sys_i;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // threshold in mv; kind 0 hot, 1 warm, 2 cool, 3 cold
    function automatic logic [10:0] thr_mv(input int kind, input logic [1:0] c);
        logic [10:0] t [4][4] = '{'{11'h19b, 11'h16f, 11'h147, 11'h123},
                                  '{11'h1ff, 11'h1cb, 11'h19b, 11'h16f},
                                  '{11'h39b, 11'h363, 11'h327, 11'h2eb},
                                  '{11'h400, 11'h3d0, 11'h39b, 11'h363}};
        return t[kind][c];
    endfunction : thr_mv

    // codes above four stay reserved in both orders and give no current
    function automatic logic [8:0] ilim_ma(input logic [2:0] c, input logic rev);
        if (c > 3'h4) return 9'h000;
        return 9'h05f * (rev ? 9'(3'h5 - c) : 9'(c + 3'h1));
    endfunction : ilim_ma

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_thr(input logic [7:0] v);
        chk(16'(hot_o), 16'(thr_mv(0, v[7:6])), "hot");
        chk(16'(warm_o), 16'(thr_mv(1, v[5:4])), "warm");
        chk(16'(cool_o), 16'(thr_mv(2, v[3:2])), "cool");
        chk(16'(cold_o), 16'(thr_mv(3, v[1:0])), "cold");
    endtask : chk_thr

    task automatic chk_cfg(input logic [7:0] v);
        chk(16'(vmin_o), 16'(13'h0fa0 + 13'h064 * v[7:5]), "vmin");
        chk(16'(ilim_o), 16'(ilim_ma(v[4:2], order)), "ilim");
        chk(16'(rsvd_o), 16'(v[4:2] > 3'h4), "ilim reserved");
        chk(16'(pq_o), v[1] ? 16'h0014 : 16'h000a, "precharge");
        chk(16'(en_o), 16'(v[0]), "enable");
    endtask : chk_cfg

    // write a byte, read it back and compare
    task automatic wr_rd(input logic [7:0] p, input logic [7:0] v, input logic [7:0] exp);
        logic [15:0] rd;
        logic        ok;
        host_u.write_regs(DEV, p, 16'(v), 1, ok);
        chk(16'(ok), 16'h0001, "write ack");
        host_u.read_regs(DEV, p, 1, rd, ok);
        chk(16'(ok), 16'h0001, "read ack");
        chk(rd, 16'(exp), "read back");
    endtask : wr_rd

    task automatic do_reset(input logic f);
        otp = f;
        srst_i = 1'b1;
        repeat (16) @(negedge clk_sys_i);
        srst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask : do_reset

    task automatic finish_test();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // watchdog cuts a hung run short
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_errors++;
        $display("wrong value at %0t: run timed out", $time);
        finish_test();
    end

    // main sequence
    initial begin : main
        logic [15:0] rd;
        logic        ok;
        logic [7:0]  v, m;
        logic [6:0]  f;
        evt = 7'h00;
        order = 1'b0;
        do_reset(1'b1);
        chk_thr(8'h0f);
        chk_cfg(8'h11);
        host_u.read_regs(DEV, `CMR_OFS_INPUT_CFG, 1, rd, ok);
        chk(rd, 16'h0011, "input config reset");
        // every threshold code, then random fields
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? {4{2'(i)}} : 8'(xs());
            wr_rd(`CMR_OFS_THERM_THR, v, v);
            chk_thr(v);
        end
        // every voltage and limit code in both orders, then random bytes
        for (int i = 0; i < 20; i++) begin
            v = (i < 16) ? {3'(i), 3'(i), 2'(i)} : 8'(xs());
            order = (i < 16) ? 1'(i >> 3) : 1'(xs());
            wr_rd(`CMR_OFS_INPUT_CFG, v, v);
            chk_cfg(v);
        end
        // burst write across two registers, pointer advancing, read back as a pair
        host_u.write_regs(DEV, `CMR_OFS_THERM_THR, 16'h8d5a, 2, ok);
        host_u.read_regs(DEV, `CMR_OFS_THERM_THR, 2, rd, ok);
        chk(rd, 16'h8d5a, "burst");
        chk_thr(8'h5a);
        // unmapped pointer reads zero; a foreign address is not acked
        wr_rd(8'h30, 8'h77, 8'h00);
        host_u.write_regs(DEV ^ 7'h01, `CMR_OFS_INPUT_CFG, 16'h0000, 1, ok);
        chk(16'(ok), 16'h0000, "foreign address nack");
        chk_cfg(8'h8d);
        // mask walk: each single bit, then random masks, bit 7 always written 0
        for (int i = 0; i < 12; i++) begin
            m = (i < 7) ? (~(8'h01 << i) & 8'h7f) : (8'(xs()) & 8'h7f);
            host_u.write_regs(DEV, `CMR_OFS_IRQ_MASK, 16'(m), 1, ok);
            host_u.read_regs(DEV, `CMR_OFS_IRQ_MASK, 1, rd, ok);
            chk(16'(rd[6:0]), 16'(m[6:0]), "mask");
            for (int k = 0; k < 4; k++) begin
                f = (k == 0) ? ~m[6:0] : (k == 1) ? m[6:0] : 7'(xs());
                evt = f;
                repeat (3) @(negedge clk_sys_i);
                chk(16'(irq_o), 16'(|(f & ~m[6:0])), "irq");
            end
        end
        // second reset with the factory bit low: all masked, charger off
        evt = 7'h7f;
        do_reset(1'b0);
        chk(16'(irq_o), 16'h0000, "irq after reset");
        chk_cfg(8'h10);
        host_u.read_regs(DEV, `CMR_OFS_IRQ_MASK, 1, rd, ok);
        chk(16'(rd[6:0]), 16'h007f, "mask reset");
        finish_test();
    end
endmodule : cmr_regs_bench

`default_nettype wire
